/* File: rtl/lfp_defs.vh */
// Purpose: constants for the lock and fuse protection block
// Assumes: 32-bit register port, byte addresses
// Notes: bit value 0 means programmed, 1 means unprogrammed
`ifndef LFP_DEFS_VH
`define LFP_DEFS_VH

// register byte offsets
`define LFP_REG_LOCK 8'h00
`define LFP_REG_FUSE_HIGH 8'h04
`define LFP_REG_FUSE_LOW 8'h08
`define LFP_REG_DATA 8'h0C
`define LFP_REG_CMD 8'h10
`define LFP_REG_STATUS 8'h14
`define LFP_REG_RESULT 8'h18

// reset values of the non-volatile bits
`define LFP_LOCK_RESET 6'h3F
`define LFP_FUSE_HIGH_RESET 7'h4F
`define LFP_FUSE_LOW_RESET 6'h32

// lock bit positions
`define LFP_LK_MEM_LOW 0
`define LFP_LK_MEM_HIGH 1
`define LFP_LK_APP_LOW 2
`define LFP_LK_APP_HIGH 3
`define LFP_LK_BOOT_LOW 4
`define LFP_LK_BOOT_HIGH 5

// high fuse positions
`define LFP_FH_BOOT_RESET 0
`define LFP_FH_BOOT_SIZE_LO 1
`define LFP_FH_BOOT_SIZE_HI 2
`define LFP_FH_EEPROM_PRESERVE 3
`define LFP_FH_SERIAL_PROG 4
`define LFP_FH_JTAG 5
`define LFP_FH_DEBUG 6

// low fuse positions
`define LFP_FL_CLOCK_SEL_HI 3
`define LFP_FL_BROWNOUT_ENABLE 4
`define LFP_FL_BROWNOUT_LEVEL 5

// command register fields
`define LFP_CMD_OP_HI 3
`define LFP_CMD_IF_LO 4
`define LFP_CMD_IF_HI 5

// command codes
`define LFP_OP_WRITE_FLASH 4'h1
`define LFP_OP_WRITE_EEPROM 4'h2
`define LFP_OP_READ_FLASH 4'h3
`define LFP_OP_READ_EEPROM 4'h4
`define LFP_OP_WRITE_FUSE_HIGH 4'h5
`define LFP_OP_WRITE_FUSE_LOW 4'h6
`define LFP_OP_WRITE_LOCK 4'h7
`define LFP_OP_READ_FUSE_LOCK 4'h8
`define LFP_OP_CHIP_ERASE 4'h9

// programming interface codes
`define LFP_IF_PARALLEL 2'h0
`define LFP_IF_SERIAL 2'h1
`define LFP_IF_JTAG 2'h2

// status bits
`define LFP_ST_BUSY 0
`define LFP_ST_ACCEPTED 1
`define LFP_ST_REFUSED 2
`define LFP_ST_FUSE_LOCKED 3
`define LFP_ST_MEM_WRITE_LOCKED 4
`define LFP_ST_MEM_READ_LOCKED 5

`endif

/* File: rtl/lfp_protect.v */
// Purpose: lock bit and fuse bit store with the protection decode
// Assumes: one clock, programmer commands arrive on the register port
// Notes: storage is flip-flops standing in for the non-volatile cells
// Overview of operation
// - six lock bits, 1 unprogrammed, 0 programmed, decide all protection
// - lock bits return to 1 only through a chip erase
// - memory lock 10 refuses flash and eeprom writes and locks fuses
// - memory lock 00 also refuses read-back of flash and eeprom
// - application lock 10 or 00 blocks stores into application section
// - application lock 00 or 01 blocks boot code reading application
// - same modes mask interrupts in application code with boot vectors
// - boot lock 10 or 00 blocks stores into boot section
// - boot lock 00 or 01 blocks application code reading boot section
// - same modes mask interrupts in boot code with application vectors
// - thirteen fuses, high and low group, open to parallel and jtag
// - serial programming can neither read nor change serial enable fuse
// - debug only when debug and jtag fuses programmed; debug default 1
// - programmed debug fuse keeps clocks running in every sleep mode
// - programmed jtag fuse routes jtag onto port pins; default 0
// - programmed serial enable fuse allows serial download; default 0
// - programmed eeprom preserve fuse keeps eeprom over erase; default 1
// - eeprom preserve fuse cannot be programmed while any lock programmed
// - boot reset fuse 0 selects boot start by size fuses, 1 selects zero
// - brown-out enable fuse 0 enables detection; both brown-out fuses default 1
// - four clock select fuses pick clock and start-up, default 0010
// - chip erase keeps fuses; programmed low memory lock freezes fuses
// - lock bits stay programmed until flash erase has fully completed
//
// The strobed register port and the register offsets were decided locally.
`include "lfp_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module lfp_protect #(
  parameter ADDR_W = 8,
  parameter DATA_W = 32
) (
  input wire i_mclk,
  input wire i_resetn,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [DATA_W-1:0] o_rdata,
  input wire i_spm_req,
  input wire i_spm_target_boot,
  input wire i_lpm_req,
  input wire i_lpm_target_boot,
  input wire i_exec_in_boot,
  input wire i_vectors_in_boot,
  output wire o_spm_allow,
  output wire o_lpm_allow,
  output wire o_int_disable,
  output reg o_mem_write_go,
  output reg o_mem_read_go,
  output reg o_mem_is_eeprom,
  output reg o_flash_erase,
  output reg o_eeprom_erase,
  input wire i_flash_erase_done,
  output wire o_debug_enable,
  output wire o_sleep_clock_keep,
  output wire o_jtag_pins_enable,
  output wire o_serial_prog_enable,
  output wire o_eeprom_preserve,
  output wire o_reset_vector_boot,
  output wire [1:0] o_boot_size,
  output wire o_brownout_enable,
  output wire o_brownout_level,
  output wire [3:0] o_clock_select
);

  localparam ST_IDLE = 1'b0;
  localparam ST_ERASE = 1'b1;

  reg [5:0] lock_bits;
  reg [6:0] fuse_high;
  reg [5:0] fuse_low;
  reg [DATA_W-1:0] data_stage;
  reg [DATA_W-1:0] result;
  reg state;
  reg accepted;
  reg refused;

  // a pair is "restricted" when its low bit is programmed
  function write_block;
    input [1:0] pair;
    begin
      write_block = ~pair[0];
    end
  endfunction

  // a pair blocks cross-section reads when its high bit is programmed
  function read_block;
    input [1:0] pair;
    begin
      read_block = ~pair[1];
    end
  endfunction

  wire [1:0] mem_pair = {lock_bits[`LFP_LK_MEM_HIGH], lock_bits[`LFP_LK_MEM_LOW]};
  wire [1:0] app_pair = {lock_bits[`LFP_LK_APP_HIGH], lock_bits[`LFP_LK_APP_LOW]};
  wire [1:0] boot_pair = {lock_bits[`LFP_LK_BOOT_HIGH], lock_bits[`LFP_LK_BOOT_LOW]};

  wire mem_lock_low = lock_bits[`LFP_LK_MEM_LOW];
  wire mem_lock_high = lock_bits[`LFP_LK_MEM_HIGH];

  // memory lock decode for the programming interfaces
  wire mem_write_locked = (mem_pair != 2'h3);
  wire mem_read_locked = ~mem_lock_high;
  wire fuses_locked = ~mem_lock_low;
  wire any_lock_programmed = (lock_bits != `LFP_LOCK_RESET);

  // self-programming store and load gating
  wire spm_app_block = write_block(app_pair) & ~i_spm_target_boot;
  wire spm_boot_block = write_block(boot_pair) & i_spm_target_boot;
  wire lpm_app_block = read_block(app_pair) & i_exec_in_boot & ~i_lpm_target_boot;
  wire lpm_boot_block = read_block(boot_pair) & ~i_exec_in_boot & i_lpm_target_boot;

  assign o_spm_allow = i_spm_req & ~spm_app_block & ~spm_boot_block;
  assign o_lpm_allow = i_lpm_req & ~lpm_app_block & ~lpm_boot_block;
  assign o_int_disable = (read_block(app_pair) & i_vectors_in_boot & ~i_exec_in_boot) |
                         (read_block(boot_pair) & ~i_vectors_in_boot & i_exec_in_boot);

  // fuse effects
  wire debug_fuse = fuse_high[`LFP_FH_DEBUG];
  wire jtag_fuse = fuse_high[`LFP_FH_JTAG];
  assign o_debug_enable = ~debug_fuse & ~jtag_fuse;
  assign o_sleep_clock_keep = ~debug_fuse;
  assign o_jtag_pins_enable = ~jtag_fuse;
  assign o_serial_prog_enable = ~fuse_high[`LFP_FH_SERIAL_PROG];
  assign o_eeprom_preserve = ~fuse_high[`LFP_FH_EEPROM_PRESERVE];
  assign o_reset_vector_boot = ~fuse_high[`LFP_FH_BOOT_RESET];
  assign o_boot_size = fuse_high[`LFP_FH_BOOT_SIZE_HI:`LFP_FH_BOOT_SIZE_LO];
  assign o_brownout_enable = ~fuse_low[`LFP_FL_BROWNOUT_ENABLE];
  assign o_brownout_level = fuse_low[`LFP_FL_BROWNOUT_LEVEL];
  assign o_clock_select = fuse_low[`LFP_FL_CLOCK_SEL_HI:0];

  // command decode
  wire cmd_wr = i_wr & (i_addr == `LFP_REG_CMD);
  wire [3:0] cmd_op = i_wdata[`LFP_CMD_OP_HI:0];
  wire [1:0] cmd_if = i_wdata[`LFP_CMD_IF_HI:`LFP_CMD_IF_LO];
  wire cmd_serial = (cmd_if == `LFP_IF_SERIAL);
  wire cmd_if_ok = (cmd_if != 2'h3);
  wire serial_off = cmd_serial & fuse_high[`LFP_FH_SERIAL_PROG];

  // fuse write values with the serial-enable fuse shielded on serial
  wire [6:0] stage_high = data_stage[6:0];
  wire [6:0] keep_serial = {stage_high[6:5], fuse_high[`LFP_FH_SERIAL_PROG], stage_high[3:0]};
  wire [6:0] high_masked = cmd_serial ? keep_serial : stage_high;
  wire eeprom_preserve_fuse_illegal = ~high_masked[`LFP_FH_EEPROM_PRESERVE] & fuse_high[`LFP_FH_EEPROM_PRESERVE] &
                        any_lock_programmed;
  wire [6:0] high_final = eeprom_preserve_fuse_illegal ?
                          {high_masked[6:4], 1'b1, high_masked[2:0]} : high_masked;

  // result of a fuse and lock read
  wire [6:0] high_view = cmd_serial ?
                         {fuse_high[6:5], 1'b1, fuse_high[3:0]} : fuse_high;
  // lock in [5:0], high fuses in [14:8], low fuses in [21:16]
  wire [DATA_W-1:0] fuse_lock_view = {{(DATA_W-22){1'b0}}, fuse_low, 1'b0, high_view, 2'h0, lock_bits};

  reg next_ok;
  reg next_write_go;
  reg next_read_go;
  reg next_erase;

  always @* begin
    next_ok = 1'b0;
    next_write_go = 1'b0;
    next_read_go = 1'b0;
    next_erase = 1'b0;
    if (cmd_wr && state == ST_IDLE && cmd_if_ok && !serial_off) begin
      case (cmd_op)
        `LFP_OP_WRITE_FLASH, `LFP_OP_WRITE_EEPROM: begin
          next_ok = ~mem_write_locked;
          next_write_go = ~mem_write_locked;
        end
        `LFP_OP_READ_FLASH, `LFP_OP_READ_EEPROM: begin
          next_ok = ~mem_read_locked;
          next_read_go = ~mem_read_locked;
        end
        `LFP_OP_WRITE_FUSE_HIGH: begin
          next_ok = ~fuses_locked & ~eeprom_preserve_fuse_illegal;
        end
        `LFP_OP_WRITE_FUSE_LOW: begin
          next_ok = ~fuses_locked;
        end
        `LFP_OP_WRITE_LOCK, `LFP_OP_READ_FUSE_LOCK: begin
          next_ok = 1'b1;
        end
        `LFP_OP_CHIP_ERASE: begin
          next_ok = 1'b1;
          next_erase = 1'b1;
        end
        default: begin
          next_ok = 1'b0;
        end
      endcase
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      lock_bits <= `LFP_LOCK_RESET;
      fuse_high <= `LFP_FUSE_HIGH_RESET;
      fuse_low <= `LFP_FUSE_LOW_RESET;
      data_stage <= {DATA_W{1'b0}};
      result <= {DATA_W{1'b0}};
      state <= ST_IDLE;
      accepted <= 1'b0;
      refused <= 1'b0;
      o_mem_write_go <= 1'b0;
      o_mem_read_go <= 1'b0;
      o_mem_is_eeprom <= 1'b0;
      o_flash_erase <= 1'b0;
      o_eeprom_erase <= 1'b0;
    end else begin
      o_mem_write_go <= next_write_go;
      o_mem_read_go <= next_read_go;
      o_eeprom_erase <= 1'b0;
      if (i_wr && i_addr == `LFP_REG_DATA) begin
        data_stage <= i_wdata;
      end
      if (cmd_wr) begin
        accepted <= next_ok;
        refused <= ~next_ok;
        if (next_write_go || next_read_go) begin
          o_mem_is_eeprom <= (cmd_op == `LFP_OP_WRITE_EEPROM) || (cmd_op == `LFP_OP_READ_EEPROM);
        end
      end
      if (next_ok) begin
        case (cmd_op)
          `LFP_OP_WRITE_FUSE_HIGH: begin
            fuse_high <= high_final;
          end
          `LFP_OP_WRITE_FUSE_LOW: begin
            fuse_low <= data_stage[5:0];
          end
          `LFP_OP_WRITE_LOCK: begin
            lock_bits <= lock_bits & data_stage[5:0];
          end
          `LFP_OP_READ_FUSE_LOCK: begin
            result <= fuse_lock_view;
          end
          default: begin
            result <= result;
          end
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (next_erase) begin
            state <= ST_ERASE;
            o_flash_erase <= 1'b1;
            o_eeprom_erase <= fuse_high[`LFP_FH_EEPROM_PRESERVE];
          end
        end
        ST_ERASE: begin
          if (i_flash_erase_done) begin
            state <= ST_IDLE;
            o_flash_erase <= 1'b0;
            lock_bits <= `LFP_LOCK_RESET;
          end
        end
        default: begin
          state <= ST_IDLE;
          o_flash_erase <= 1'b0;
        end
      endcase
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= {DATA_W{1'b0}};
    end else if (i_rd) begin
      case (i_addr)
        `LFP_REG_LOCK: o_rdata <= {{(DATA_W-6){1'b0}}, lock_bits};
        `LFP_REG_FUSE_HIGH: o_rdata <= {{(DATA_W-7){1'b0}}, fuse_high};
        `LFP_REG_FUSE_LOW: o_rdata <= {{(DATA_W-6){1'b0}}, fuse_low};
        `LFP_REG_DATA: o_rdata <= data_stage;
        `LFP_REG_STATUS: o_rdata <= {{(DATA_W-6){1'b0}}, mem_read_locked, mem_write_locked,
                                     fuses_locked, refused, accepted, state};
        `LFP_REG_RESULT: o_rdata <= result;
        default: o_rdata <= {DATA_W{1'b0}};
      endcase
    end else begin
      o_rdata <= {DATA_W{1'b0}};
    end
  end

endmodule

`default_nettype wire

/* File: rtl/lfp_protect_unused_guard.v */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: sim/lfp_flash_model.sv */
// Purpose: flash array stand-in that answers a chip erase
// Assumes: erase request is a level from the protection block
// Notes: done is one pulse after a fixed count
`timescale 1ns/1ns
`default_nettype none
module lfp_flash_model #(
  parameter int ERASE_CYCLES = 20
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_erase,
  output logic o_done
);
  int cnt;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 0;
      o_done <= 1'b0;
    end else begin
      cnt <= (i_erase && !o_done) ? cnt + 1 : 0;
      o_done <= i_erase && !o_done && cnt == ERASE_CYCLES - 1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/lfp_protect_properties.sv */
// Purpose: port checker for the lock and fuse protection block
// Assumes: bound into lfp_protect
// Notes: fuse outputs may change only after a register write
`timescale 1ns/1ns
`default_nettype none
module lfp_protect_properties (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_spm_req,
  input wire logic i_lpm_req,
  input wire logic i_flash_erase_done,
  input wire logic [31:0] o_rdata,
  input wire logic o_spm_allow,
  input wire logic o_lpm_allow,
  input wire logic o_mem_write_go,
  input wire logic o_flash_erase,
  input wire logic o_eeprom_erase,
  input wire logic o_debug_enable,
  input wire logic o_sleep_clock_keep,
  input wire logic o_jtag_pins_enable,
  input wire logic [1:0] o_boot_size,
  input wire logic [3:0] o_clock_select
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_erase_end;
    o_flash_erase && i_flash_erase_done;
  endsequence
  sequence s_pulse_gone;
    ##1 !o_eeprom_erase;
  endsequence
  a_erase_stops: assert property (s_erase_end |=> !o_flash_erase)
    else $error("erase still running after done");
  a_erase_cause: assert property ($rose(o_flash_erase) |-> $past(i_wr))
    else $error("erase started without a command");
  a_eeprom_pulse: assert property (o_eeprom_erase |-> o_flash_erase ##0 s_pulse_gone)
    else $error("eeprom erase pulse wrong");
  a_spm_gate: assert property (o_spm_allow |-> i_spm_req)
    else $error("store allowed without request");
  a_lpm_gate: assert property (o_lpm_allow |-> i_lpm_req)
    else $error("load allowed without request");
  a_debug_needs: assert property (o_debug_enable |-> o_jtag_pins_enable && o_sleep_clock_keep)
    else $error("debug on without both fuses");
  a_fuse_hold: assert property (!$past(i_wr) |-> $stable(o_clock_select) && $stable(o_boot_size))
    else $error("fuse output changed without a write");
  a_write_go: assert property (o_mem_write_go |-> $past(i_wr) ##1 !o_mem_write_go)
    else $error("write go not a single answer to a command");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind lfp_protect lfp_protect_properties u_chk (.i_mclk, .i_resetn, .i_wr, .i_rd, .i_spm_req, .i_lpm_req,
  .i_flash_erase_done, .o_rdata, .o_spm_allow, .o_lpm_allow, .o_mem_write_go, .o_flash_erase, .o_eeprom_erase,
  .o_debug_enable, .o_sleep_clock_keep, .o_jtag_pins_enable, .o_boot_size, .o_clock_select);
`default_nettype wire

/* File: sim/tb_lfp_protect.sv */
// Purpose: directed bench for lock and fuse protection
// Assumes: programmer commands over the register port
// Notes: locks are programmed step by step, then a chip erase
`include "lfp_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_lfp_protect;
  logic i_mclk, i_resetn, i_wr, i_rd, i_spm_req, i_spm_target_boot, i_lpm_req, i_lpm_target_boot;
  logic i_exec_in_boot, i_vectors_in_boot, i_flash_erase_done, wgo, rgo, eg;
  logic o_spm_allow, o_lpm_allow, o_int_disable, o_mem_write_go, o_mem_read_go, o_mem_is_eeprom;
  logic o_flash_erase, o_eeprom_erase, o_debug_enable, o_sleep_clock_keep, o_jtag_pins_enable;
  logic o_serial_prog_enable, o_eeprom_preserve, o_reset_vector_boot, o_brownout_enable, o_brownout_level;
  logic [1:0] o_boot_size;
  logic [3:0] o_clock_select;
  logic [2:0] r;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, q;
  int mismatches, cmp_count;
  lfp_protect DUT (.*);
  lfp_flash_model #(.ERASE_CYCLES(20)) u_mem (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_erase(o_flash_erase),
    .o_done(i_flash_erase_done));
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
  endtask
  // data staging, command, then accepted or refused from status
  task automatic cmd(input logic [1:0] ifc, input logic [3:0] op, input logic [31:0] d, input logic ok);
    wr(`LFP_REG_DATA, d);
    wr(`LFP_REG_CMD, {26'h0, ifc, op});
    #1;
    wgo = o_mem_write_go;
    rgo = o_mem_read_go;
    eg = o_eeprom_erase;
    rd(`LFP_REG_STATUS);
    chk(32'(q[2:1]), ok ? 32'h1 : 32'h2);
  endtask
  // {store target boot, load target boot, exec in boot, vectors in boot}
  task automatic cpu(input logic [3:0] v);
    @(posedge i_mclk);
    {i_spm_target_boot, i_lpm_target_boot, i_exec_in_boot, i_vectors_in_boot} <= v;
    @(posedge i_mclk);
    #1;
    r = {o_spm_allow, o_lpm_allow, o_int_disable};
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    {i_resetn, i_wr, i_rd, i_spm_target_boot, i_lpm_target_boot, i_exec_in_boot, i_vectors_in_boot} = '0;
    {i_addr, i_wdata} = '0;
    i_spm_req = 1'b1;
    i_lpm_req = 1'b1;
    repeat (5) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rd(`LFP_REG_LOCK); chk(q, 32'h3F);
    rd(`LFP_REG_FUSE_HIGH); chk(q, 32'h4F);
    rd(`LFP_REG_FUSE_LOW); chk(q, 32'h32);
    rd(8'h40); chk(q, 32'h0);
    chk(32'({o_debug_enable, o_sleep_clock_keep, o_jtag_pins_enable, o_serial_prog_enable, o_eeprom_preserve}),
      32'h06);
    chk(32'({o_reset_vector_boot, o_boot_size, o_brownout_enable, o_brownout_level, o_clock_select}),
      32'h0D2);
    cpu(4'b0000); chk(32'(r), 32'h6);
    cmd(`LFP_IF_SERIAL, `LFP_OP_WRITE_FUSE_HIGH, 32'h1F, 1'b1);
    rd(`LFP_REG_FUSE_HIGH); chk(q, 32'h0F);
    chk(32'({o_debug_enable, o_sleep_clock_keep}), 32'h3);
    cmd(`LFP_IF_SERIAL, `LFP_OP_READ_FUSE_LOCK, 32'h0, 1'b1);
    rd(`LFP_REG_RESULT); chk(q, 32'h00321F3F);
    cmd(`LFP_IF_JTAG, `LFP_OP_WRITE_FUSE_HIGH, 32'h4F, 1'b1);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_FUSE_LOW, 32'h22, 1'b1);
    chk(32'(o_brownout_enable), 32'h1);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_FLASH, 32'h0, 1'b1); chk(32'(wgo), 32'h1);
    chk(32'(o_mem_is_eeprom), 32'h0);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_EEPROM, 32'h0, 1'b1); chk(32'(o_mem_is_eeprom), 32'h1);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_LOCK, 32'h3B, 1'b1);
    rd(`LFP_REG_LOCK); chk(q, 32'h3B);
    cpu(4'b0000); chk(32'(r), 32'h2);
    cpu(4'b1100); chk(32'(r), 32'h6);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_LOCK, 32'h33, 1'b1);
    cpu(4'b0011); chk(32'(r), 32'h0);
    cpu(4'b0001); chk(32'(r), 32'h3);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_FUSE_HIGH, 32'h47, 1'b0);
    rd(`LFP_REG_FUSE_HIGH); chk(q, 32'h4F);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_LOCK, 32'h03, 1'b1);
    cpu(4'b1100); chk(32'(r), 32'h0);
    cpu(4'b1110); chk(32'(r), 32'h3);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_LOCK, 32'h3F, 1'b1);
    rd(`LFP_REG_LOCK); chk(q, 32'h03);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_LOCK, 32'h02, 1'b1);
    cmd(`LFP_IF_JTAG, `LFP_OP_WRITE_FLASH, 32'h0, 1'b0);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_FUSE_LOW, 32'h32, 1'b0);
    cmd(`LFP_IF_SERIAL, `LFP_OP_READ_FLASH, 32'h0, 1'b1); chk(32'(rgo), 32'h1);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_WRITE_LOCK, 32'h00, 1'b1);
    cmd(`LFP_IF_JTAG, `LFP_OP_READ_FLASH, 32'h0, 1'b0);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_READ_EEPROM, 32'h0, 1'b0);
    cmd(`LFP_IF_PARALLEL, `LFP_OP_CHIP_ERASE, 32'h0, 1'b1); chk(32'(eg), 32'h1);
    rd(`LFP_REG_LOCK); chk(q, 32'h00);
    for (int i = 0; i < 100 && o_flash_erase !== 1'b0; i++) @(posedge i_mclk);
    chk(32'(o_flash_erase), 32'h0);
    rd(`LFP_REG_LOCK); chk(q, 32'h3F);
    rd(`LFP_REG_FUSE_LOW); chk(q, 32'h22);
    final_report();
  end
endmodule
`default_nettype wire
